//--- core/scfg_pkg.sv
// Package for the slot capability configuration bits
`default_nettype none
package scfg_pkg;
    // Field positions inside the downstream port general control word
    localparam int SCFG_AIP_BIT = 11;
    localparam int SCFG_MRL_BIT = 10;
    localparam int SCFG_PCP_BIT = 9;
    localparam int SCFG_ABP_BIT = 8;
    localparam int SCFG_SLOT_BIT = 7;
    localparam int SCFG_PFIP_BIT = 6;
    localparam int SCFG_LSB = 6;
    localparam int SCFG_WIDTH = 6;
    // Fixed reset value of the registered power fault output
    localparam logic SCFG_RST_ZERO = 1'h0;
    // Slot hardware description carried as one bundle
    typedef struct packed {
        logic attention_indicator_present_cfg;
        logic latch_sensor_present_cfg;
        logic power_controller_present_cfg;
        logic attention_button_present_cfg;
        logic slot_implemented_cfg;
        logic power_fault_input_present_cfg;
    } scfg_bits_t;
    // Software write request into the general control word
    typedef struct packed {
        logic wr_en;
        logic [3:0] byte_en;
        logic [31:0] data;
    } scfg_wr_t;
endpackage : scfg_pkg
`default_nettype wire

//--- core/scfg_slot_bits.sv
// Slot capability configuration bits 11..6 of the general control word
`default_nettype none
module scfg_slot_bits
    import scfg_pkg::*;
(
    input wire logic clk_i, // 25 MHz clock
    input wire logic sys_rst_i, // Fundamental reset, sync active high
    input wire logic downstream_port_strap_pin_i, // Per-port strap pin
    input wire logic power_fault_pin_i, // Power fault input pin
    input wire scfg_wr_t cfg_wr_i, // Config space write
    input wire logic eeprom_load_i, // EEPROM load strobe
    input wire scfg_bits_t eeprom_data_i, // Bits read from EEPROM
    output var scfg_bits_t slot_cfg_o, // Current bits to capability regs
    output logic [31:0] cfg_rdata_o, // Read view, bits 11..6 only
    output logic power_fault_o // Qualified power fault
);
    // Byte lane holding bits 11..8, and the one holding bits 7..6
    localparam int BYTE_W = 8;
    localparam int LANE_HI = SCFG_AIP_BIT / BYTE_W;
    localparam int LANE_LO = SCFG_PFIP_BIT / BYTE_W;

    // Strap pin synchroniser, first and second stage
    logic strap_s1_r, strap_s2_r, strap_s1_nxt, strap_s2_nxt;
    // Power fault pin synchroniser, first and second stage
    logic pf_s1_r, pf_s2_r, pf_s1_nxt, pf_s2_nxt;
    // Set through reset so the strap is taken once after release
    logic strap_pend_r, strap_pend_nxt;
    // Configuration bits, one per slot hardware feature
    scfg_bits_t bits_r, bits_nxt;
    // Registered fault output, gated by the present bit
    logic pf_out_r, pf_out_nxt;

    // The field must fit the word the read view returns
    if (SCFG_LSB + SCFG_WIDTH > $bits(cfg_rdata_o)) begin : g_chk_span
        $error("Slot field does not fit the control word");
    end
    // The bundle must carry exactly one bit per field position
    if ($bits(scfg_bits_t) != SCFG_WIDTH) begin : g_chk_size
        $error("Slot bundle width differs from field width");
    end
    // Bit positions must follow the bundle order, MSB first
    if (SCFG_PFIP_BIT != SCFG_LSB ||
        SCFG_AIP_BIT != SCFG_LSB + SCFG_WIDTH - 1) begin : g_chk_pos
        $error("Field positions disagree with bundle order");
    end

    // A lane of a software write that no load overrides this cycle
    function automatic logic lane_wr(input scfg_wr_t wr, input logic ld,
            input int lane);
        return wr.wr_en && wr.byte_en[lane] && !ld;
    endfunction

    // Next state computation
    always_comb begin
        strap_s1_nxt = downstream_port_strap_pin_i;
        strap_s2_nxt = strap_s1_r;
        pf_s1_nxt = power_fault_pin_i;
        pf_s2_nxt = pf_s1_r;
        bits_nxt = bits_r;
        strap_pend_nxt = 1'h0;
        if (sys_rst_i) begin
            bits_nxt = '0;
            strap_pend_nxt = 1'h1;
        end else begin
            if (strap_pend_r) begin
                bits_nxt.slot_implemented_cfg = strap_s2_r;
            end
            if (eeprom_load_i) begin
                bits_nxt = eeprom_data_i;
            end else if (cfg_wr_i.wr_en) begin
                if (cfg_wr_i.byte_en[LANE_HI]) begin
                    bits_nxt.attention_indicator_present_cfg =
                        cfg_wr_i.data[SCFG_AIP_BIT];
                    bits_nxt.latch_sensor_present_cfg =
                        cfg_wr_i.data[SCFG_MRL_BIT];
                    bits_nxt.power_controller_present_cfg =
                        cfg_wr_i.data[SCFG_PCP_BIT];
                    bits_nxt.attention_button_present_cfg =
                        cfg_wr_i.data[SCFG_ABP_BIT];
                end
                if (cfg_wr_i.byte_en[LANE_LO]) begin
                    bits_nxt.slot_implemented_cfg =
                        cfg_wr_i.data[SCFG_SLOT_BIT];
                    bits_nxt.power_fault_input_present_cfg =
                        cfg_wr_i.data[SCFG_PFIP_BIT];
                end
            end
        end
        // fault pin used only when enabled
        pf_out_nxt = sys_rst_i ? SCFG_RST_ZERO :
            (bits_r.power_fault_input_present_cfg & pf_s2_r);
    end

    // Register stage
    always_ff @(posedge clk_i) begin
        strap_s1_r <= strap_s1_nxt;
        strap_s2_r <= strap_s2_nxt;
        pf_s1_r <= pf_s1_nxt;
        pf_s2_r <= pf_s2_nxt;
        strap_pend_r <= strap_pend_nxt;
        bits_r <= bits_nxt;
        pf_out_r <= pf_out_nxt;
    end

    assign slot_cfg_o = bits_r;
    assign power_fault_o = pf_out_r;

    // Read view: other bits of the word belong elsewhere
    always_comb begin
        cfg_rdata_o = '0;
        cfg_rdata_o[SCFG_LSB +: SCFG_WIDTH] = bits_r;
    end

    // Assertions
    // reset clears bits
    a_reset_clears: assert property (@(posedge clk_i)
        sys_rst_i |=> bits_r == '0)
        else $error("Reset did not clear slot bits");
    a_strap_default: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        strap_pend_r && !eeprom_load_i && !cfg_wr_i.wr_en
        |=> bits_r.slot_implemented_cfg == $past(strap_s2_r))
        else $error("Slot bit did not take strap level");
    a_eeprom_load: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        eeprom_load_i |=> bits_r == $past(eeprom_data_i))
        else $error("EEPROM value not loaded");
    a_aip_write: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        cfg_wr_i.wr_en && cfg_wr_i.byte_en[1] && !eeprom_load_i
        |=> cfg_rdata_o[SCFG_AIP_BIT] == $past(cfg_wr_i.data[SCFG_AIP_BIT]))
        else $error("Attention indicator write lost");
    a_mrl_write: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        cfg_wr_i.wr_en && cfg_wr_i.byte_en[1] && !eeprom_load_i
        |=> slot_cfg_o.latch_sensor_present_cfg
            == $past(cfg_wr_i.data[SCFG_MRL_BIT]))
        else $error("Latch sensor write lost");
    a_slot_write: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        cfg_wr_i.wr_en && cfg_wr_i.byte_en[0] && !eeprom_load_i
        |=> slot_cfg_o.slot_implemented_cfg
            == $past(cfg_wr_i.data[SCFG_SLOT_BIT]))
        else $error("Slot implemented write lost");
    a_pf_gate: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        !bits_r.power_fault_input_present_cfg |=> !power_fault_o)
        else $error("Power fault passed while disabled");
    a_hold_idle: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        !eeprom_load_i && !cfg_wr_i.wr_en && !strap_pend_r
        |=> $stable(bits_r))
        else $error("Bits changed without a write");
    a_cap_follow: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        lane_wr(cfg_wr_i, eeprom_load_i, LANE_HI)
        |=> slot_cfg_o.attention_indicator_present_cfg
            == $past(cfg_wr_i.data[SCFG_AIP_BIT]))
        else $error("Capability field missed attention bit");
    a_pcp_write: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        lane_wr(cfg_wr_i, eeprom_load_i, LANE_HI)
        |=> slot_cfg_o.power_controller_present_cfg
            == $past(cfg_wr_i.data[SCFG_PCP_BIT]))
        else $error("Power controller write lost");
    a_abp_write: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        lane_wr(cfg_wr_i, eeprom_load_i, LANE_HI)
        |=> slot_cfg_o.attention_button_present_cfg
            == $past(cfg_wr_i.data[SCFG_ABP_BIT]))
        else $error("Attention button write lost");
    a_pfip_write: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        lane_wr(cfg_wr_i, eeprom_load_i, LANE_LO)
        |=> slot_cfg_o.power_fault_input_present_cfg
            == $past(cfg_wr_i.data[SCFG_PFIP_BIT]))
        else $error("Power fault present write lost");
    a_pf_pass: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        bits_r.power_fault_input_present_cfg && pf_s2_r |=> power_fault_o)
        else $error("Power fault lost while enabled");
    // Coverage of the main scenarios
    c_eeprom: cover property (@(posedge clk_i) eeprom_load_i);
    // Strap taken as slot default right after release
    c_strap: cover property (@(posedge clk_i)
        !sys_rst_i && strap_pend_r && strap_s2_r);
    // Load and write in one cycle, the load wins
    c_load_write: cover property (@(posedge clk_i)
        eeprom_load_i && cfg_wr_i.wr_en);
    c_write: cover property (@(posedge clk_i)
        cfg_wr_i.wr_en && cfg_wr_i.byte_en[1]);
    c_fault: cover property (@(posedge clk_i) power_fault_o);
endmodule : scfg_slot_bits
`default_nettype wire

//--- verif/tb_scfg_slot_bits.sv
// Self-checking bench for the slot capability configuration bits
`default_nettype none
module tb_scfg_slot_bits import scfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0; // Bench clock
    logic sys_rst_i = 1'b1; // Fundamental reset
    logic strap_i = 1'b0; // Port strap level
    logic pf_pin_i = 1'b0; // Power fault pin level
    logic eeprom_load_i = 1'b0; // EEPROM load strobe
    scfg_wr_t cfg_wr_i = '0; // Config write request
    scfg_bits_t eeprom_data_i = '0; // EEPROM image
    scfg_bits_t slot_cfg_o; // Bits seen by capability fields
    logic [31:0] cfg_rdata_o; // Read view of the word
    logic power_fault_o; // Qualified fault
    int fails = 0; // Mismatch count
    int checks_done = 0; // Comparison count
    logic [5:0] exp_bits; // Model state after the latest request
    logic [5:0] prev_bits; // Model state the design shows now
    logic [5:0] exp_q[$]; // Expected results still in flight
    logic [31:0] seed = 32'h24; // Xorshift state
    logic [31:0] r; // Random word
    scfg_slot_bits uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .downstream_port_strap_pin_i(strap_i), .power_fault_pin_i(pf_pin_i),
        .cfg_wr_i(cfg_wr_i), .eeprom_load_i(eeprom_load_i),
        .eeprom_data_i(eeprom_data_i), .slot_cfg_o(slot_cfg_o),
        .cfg_rdata_o(cfg_rdata_o), .power_fault_o(power_fault_o));
    // Clock at 40 ns period
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // Xorshift source of stimulus
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Compare both bit views with the model
    task chk_bits();
        prev_bits = exp_q.pop_front();
        checks_done++;
        if (slot_cfg_o !== prev_bits ||
                cfg_rdata_o !== {20'h0, prev_bits, 6'h0}) begin
            fails++;
            $display("unexpected slot bits: expected %h seen %h word %h",
                prev_bits, slot_cfg_o, cfg_rdata_o);
        end
    endtask
    // Compare the qualified fault output
    task chk_pf(input logic e);
        checks_done++;
        if (power_fault_o !== e) begin
            fails++;
            $display("unexpected power_fault_o: expected %b seen %b",
                e, power_fault_o);
        end
    endtask
    // One request per cycle; results of the previous one are checked
    task op(input logic we, input logic [3:0] be, input logic [31:0] d,
            input logic ld, input logic [5:0] ed);
        @(posedge clk_i);
        cfg_wr_i <= {we, be, d};
        eeprom_load_i <= ld;
        eeprom_data_i <= ed;
        exp_q.push_back(exp_bits);
        if (ld) begin
            exp_bits = ed; // Load beats a write in the same cycle
        end else if (we) begin
            if (be[1]) exp_bits[5:2] = d[11:8];
            if (be[0]) exp_bits[1:0] = d[7:6];
        end
        @(negedge clk_i);
        chk_bits();
    endtask
    // Reset with a given strap level, then let the strap be captured
    task rst(input logic s);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        strap_i <= s;
        cfg_wr_i <= '0;
        eeprom_load_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        exp_bits = {4'h0, s, 1'b0};
        @(posedge clk_i);
    endtask
    // One random request: write, load or idle
    task rnd_op();
        r = xs();
        op(r[0], r[4:1], xs(), r[6:5] == 2'h0, r[12:7]);
    endtask
    // Print the verdict and stop
    task end_sim();
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        rst(1'b1);
        op(1'b0, 4'h0, 32'h0, 1'b0, 6'h0);
        repeat (100) begin
            rnd_op();
            rnd_op();
            rnd_op();
        end
        for (int j = 0; j < 4; j++) begin
            op(1'b1, 4'h1, {25'h0, j[0], 6'h0}, 1'b0, 6'h0);
            @(posedge clk_i);
            cfg_wr_i <= '0;
            pf_pin_i <= j[1];
            repeat (5) op(1'b0, 4'h0, 32'h0, 1'b0, 6'h0);
            chk_pf(j[0] & j[1]);
        end
        rst(1'b0);
        op(1'b0, 4'h0, 32'h0, 1'b0, 6'h0);
        chk_pf(1'b0);
        op(1'b1, 4'hF, 32'hFFFFFFFF, 1'b1, 6'h15);
        op(1'b0, 4'h0, 32'h0, 1'b0, 6'h0);
        op(1'b0, 4'h0, 32'h0, 1'b0, 6'h0);
        end_sim();
    end
endmodule // tb_scfg_slot_bits
`default_nettype wire
